// *** rtl/slv_pkg.sv ***
// Package with the register map, field layout and reset values of the bank.
package slv_pkg;
  localparam int REG_W = 16;
  localparam int NUM_REGS = 6;
  // Printed offsets are register indices; byte address is four times each.
  localparam logic [7:0] IDX_CP    = 8'h0e;
  localparam logic [7:0] IDX_FIXF  = 8'h0f;
  localparam logic [7:0] IDX_CUR   = 8'h10;
  localparam logic [7:0] IDX_FIX11 = 8'h11;
  localparam logic [7:0] IDX_FIX12 = 8'h12;
  localparam logic [7:0] IDX_BAND  = 8'h13;
  localparam logic [7:0] IDX_OVR   = 8'h14;
  localparam logic [7:0] IDX_STAT  = 8'h15;
  localparam logic [15:0] RST_CP    = 16'h1e70;
  localparam logic [15:0] RST_FIXF  = 16'h064f;
  localparam logic [15:0] RST_CUR   = 16'h0080;
  localparam logic [15:0] RST_FIX11 = 16'h0096;
  localparam logic [15:0] RST_FIX12 = 16'h0064;
  localparam logic [15:0] RST_BAND  = 16'h27b7;
  localparam logic [15:0] RST_OVR   = 16'h0000;
  localparam int GAIN_LSB = 4;
  localparam int GAIN_W = 3;
  localparam int CUR_W = 9;
  localparam int BAND_W = 8;
  localparam int CUR_OVR_BIT = 14;
  localparam int BAND_OVR_BIT = 11;
  localparam logic [7:0] BAND_MAX = 8'hb7;
  // Pump current in mA for each gain code; zero marks tri-state or unused.
  localparam logic [3:0] CP_MA_0 = 4'h0;
  localparam logic [3:0] CP_MA_4 = 4'h3;
  localparam logic [3:0] CP_MA_1 = 4'h6;
  localparam logic [3:0] CP_MA_5 = 4'h9;
  localparam logic [3:0] CP_MA_3 = 4'hc;
  localparam logic [3:0] CP_MA_7 = 4'hf;
endpackage : slv_pkg

// *** rtl/slv_pump_decode.sv ***
// Charge pump gain code decoder.
`timescale 1ns/1ns
module slv_pump_decode
  import slv_pkg::*;
(
  input  wire logic [slv_pkg::GAIN_W-1:0] gainCode,   // Gain code field.
  output logic      [3:0]                 pumpMilliAmp, // Total current.
  output logic                            pumpEnable,   // Pump not tri-stated.
  output logic                            pumpCodeBad   // Unused code.
);
  always_comb
  begin
    pumpMilliAmp = CP_MA_0;
    pumpCodeBad  = 1'b0;
    case (gainCode)
      3'h0: pumpMilliAmp = CP_MA_0;
      3'h4: pumpMilliAmp = CP_MA_4;
      3'h1: pumpMilliAmp = CP_MA_1;
      3'h5: pumpMilliAmp = CP_MA_5;
      3'h3: pumpMilliAmp = CP_MA_3;
      3'h7: pumpMilliAmp = CP_MA_7;
      default: pumpCodeBad = 1'b1;
    endcase
  end
  assign pumpEnable = (pumpMilliAmp != CP_MA_0);
endmodule : slv_pump_decode

// *** rtl/slv_regs.sv ***
// Loop and oscillator override register bank with an APB slave port.
`timescale 1ns/1ns
module slv_regs
  import slv_pkg::*;
(
  input  wire logic                          core_clk,     // 25 MHz clock.
  input  wire logic                          rst,          // Async reset.
  input  wire logic                          psel,         // APB select.
  input  wire logic                          penable,      // APB enable.
  input  wire logic                          pwrite,       // APB write.
  input  wire logic [11:0]                   paddr,        // APB byte addr.
  input  wire logic [31:0]                   pwdata,       // APB write data.
  input  wire logic [3:0]                    pstrb,        // APB strobes.
  output logic      [31:0]                   prdata,       // APB read data.
  output logic                               pready,       // APB ready.
  output logic                               pslverr,      // APB error.
  input  wire logic [slv_pkg::CUR_W-1:0]     calCurrent,   // Calibrated cur.
  input  wire logic [slv_pkg::BAND_W-1:0]    calBand,      // Calibrated band.
  output logic      [slv_pkg::CUR_W-1:0]     oscCurrent,   // Applied current.
  output logic      [slv_pkg::BAND_W-1:0]    oscBand,      // Applied band.
  output logic      [slv_pkg::GAIN_W-1:0]    chargePumpGainCode, // Gain.
  output logic      [3:0]                    pumpMilliAmp, // Pump current.
  output logic                               pumpEnable,   // Pump driving.
  output logic                               bandInvalid   // Override band over 183.
);
  import slv_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode.
  logic [15:0] regs [NUM_REGS+1];
  logic [7:0]  regIndex;
  logic        wordAligned;
  logic        hitBank;
  logic        hitStat;
  logic        accessPhase;
  logic        doWrite;
  logic [2:0]  slot;
  logic [15:0] mergedWord;
  logic [15:0] slotWord;
  logic        pumpCodeBad;

  assign regIndex    = paddr[9:2];
  assign wordAligned = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  assign hitBank     = wordAligned && regIndex >= IDX_CP
                       && regIndex <= IDX_OVR;
  assign hitStat     = wordAligned && regIndex == IDX_STAT;
  assign slot        = 3'(regIndex - IDX_CP);
  assign accessPhase = psel && penable;
  assign doWrite     = accessPhase && pwrite && hitBank;
  assign pready      = 1'b1;
  assign pslverr     = accessPhase && !(hitBank || (hitStat && !pwrite));
  // Slot seven has no storage behind it; it reads as zero, not as unknown.
  assign slotWord    = (slot <= 3'(NUM_REGS)) ? regs[slot] : 16'h0000;
  assign mergedWord  = {pstrb[1] ? pwdata[15:8] : slotWord[15:8],
                        pstrb[0] ? pwdata[7:0]  : slotWord[7:0]};

  ////////////////////////////////////////////////////////////////////////////
  // Storage; slot six holds the override selects.
  localparam logic [15:0] RESETS [NUM_REGS+1] = '{RST_CP, RST_FIXF,
    RST_CUR, RST_FIX11, RST_FIX12, RST_BAND, RST_OVR};

  for (genvar i = 0; i <= NUM_REGS; i++)
  begin : g_reg
    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
        regs[i] <= RESETS[i];
      else if (doWrite && slot == 3'(i))
        regs[i] <= mergedWord;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, captured at the end of the setup cycle and held through the
  // access phase, so that it comes from a flip-flop and stands steady at
  // the edge where the master samples it together with pready.
  // Outside a read it returns to zero one edge after the access ends.
  logic        setupPhase;
  logic [31:0] next_prdata;
  assign setupPhase  = psel && !penable && !pwrite;
  assign next_prdata = hitBank ? {16'h0000, slotWord} :
                       hitStat ? {29'h0, pumpCodeBad, bandInvalid,
                                  pumpEnable} : 32'h0;
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      prdata <= 32'h0;
    else if (setupPhase)
      prdata <= next_prdata;
    else if (!accessPhase)
      prdata <= 32'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator and pump controls.
  logic curOvr;
  logic bandOvr;
  logic outLive;

  // The registered controls hold reset values for one edge after reset
  // ends; the oscillator checks that look one edge back are held off until then.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      outLive <= 1'b0;
    else
      outLive <= 1'b1;
  end

  assign curOvr  = regs[6][CUR_OVR_BIT];
  assign bandOvr = regs[6][BAND_OVR_BIT];
  assign chargePumpGainCode = regs[0][GAIN_LSB +: GAIN_W];

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      oscCurrent  <= RST_CUR[CUR_W-1:0];
      oscBand     <= RST_BAND[BAND_W-1:0];
      bandInvalid <= 1'b0;
    end
    else
    begin
      oscCurrent  <= curOvr ? regs[2][CUR_W-1:0] : calCurrent;
      oscBand     <= bandOvr ? regs[5][BAND_W-1:0] : calBand;
      bandInvalid <= bandOvr && regs[5][BAND_W-1:0] > BAND_MAX;
    end
  end

  slv_pump_decode u_pump (
    .gainCode     (chargePumpGainCode),
    .pumpMilliAmp (pumpMilliAmp),
    .pumpEnable   (pumpEnable),
    .pumpCodeBad  (pumpCodeBad)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the oscillator controls.
  chk_cur_override: assert property (
    @(posedge core_clk) disable iff (rst)
    outLive && curOvr |=> oscCurrent == $past(regs[2][CUR_W-1:0]))
    else $error("Oscillator current ignores override.");
  chk_cur_calib: assert property (
    @(posedge core_clk) disable iff (rst)
    outLive && !curOvr |=> oscCurrent == $past(calCurrent))
    else $error("Oscillator current ignores calibration.");
  chk_band_override: assert property (
    @(posedge core_clk) disable iff (rst)
    outLive && bandOvr |=> oscBand == $past(regs[5][BAND_W-1:0]))
    else $error("Oscillator band ignores override.");
  chk_band_calib: assert property (
    @(posedge core_clk) disable iff (rst)
    outLive && !bandOvr |=> oscBand == $past(calBand))
    else $error("Oscillator band ignores calibration.");
  chk_band_range: assert property (
    @(posedge core_clk) disable iff (rst)
    bandOvr && regs[5][7:0] > 8'hb7 |=> bandInvalid)
    else $error("Out of range band not flagged.");
  chk_band_valid: assert property (
    @(posedge core_clk) disable iff (rst)
    !(bandOvr && regs[5][7:0] > 8'hb7) |=> !bandInvalid)
    else $error("Valid band flagged as invalid.");

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the pump decode.
  chk_pump_max: assert property (
    @(posedge core_clk) disable iff (rst)
    chargePumpGainCode == 3'h7 |-> pumpMilliAmp == 4'hf)
    else $error("Top gain code gives wrong current.");
  chk_pump_off: assert property (
    @(posedge core_clk) disable iff (rst)
    chargePumpGainCode == 3'h0 |-> !pumpEnable)
    else $error("Pump not tri-stated at code zero.");
  chk_pump_table: assert property (
    @(posedge core_clk) disable iff (rst)
    (chargePumpGainCode != 3'h4 || pumpMilliAmp == 4'h3)
    && (chargePumpGainCode != 3'h1 || pumpMilliAmp == 4'h6)
    && (chargePumpGainCode != 3'h5 || pumpMilliAmp == 4'h9)
    && (chargePumpGainCode != 3'h3 || pumpMilliAmp == 4'hc))
    else $error("Gain code gives wrong pump current.");
  chk_pump_unused: assert property (
    @(posedge core_clk) disable iff (rst)
    chargePumpGainCode == 3'h2 || chargePumpGainCode == 3'h6
    |-> pumpMilliAmp == 4'h0 && !pumpEnable && pumpCodeBad)
    else $error("Unused gain code drives the pump.");

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the register port.
  chk_write_back: assert property (
    @(posedge core_clk) disable iff (rst)
    doWrite && pstrb[1:0] == 2'b11
    |=> regs[$past(slot)] == $past(pwdata[15:0]))
    else $error("Written word not stored.");
  chk_strobe_keep: assert property (
    @(posedge core_clk) disable iff (rst)
    doWrite && !pstrb[1]
    |=> regs[$past(slot)][15:8] == $past(slotWord[15:8]))
    else $error("Disabled byte lane was overwritten.");
  chk_no_side_write: assert property (
    @(posedge core_clk) disable iff (rst)
    !doWrite |=> $stable(regs[2]) && $stable(regs[5]) && $stable(regs[6]))
    else $error("Register changed without a write.");
  chk_read_back: assert property (
    @(posedge core_clk) disable iff (rst)
    accessPhase && !pwrite && hitBank |-> prdata[15:0] == slotWord
    && prdata[31:16] == 16'h0)
    else $error("Read data differs from stored word.");
  chk_prdata_idle: assert property (
    @(posedge core_clk) disable iff (rst)
    !psel |=> prdata == 32'h0)
    else $error("Read data not cleared when idle.");
  chk_err_unmapped: assert property (
    @(posedge core_clk) disable iff (rst)
    accessPhase && !hitBank && !hitStat |-> pslverr)
    else $error("Unmapped access not refused.");
  chk_stat_refuse: assert property (
    @(posedge core_clk) disable iff (rst)
    accessPhase && pwrite && hitStat |-> pslverr)
    else $error("Write to status not refused.");
  chk_err_quiet: assert property (
    @(posedge core_clk) disable iff (rst)
    pslverr |-> accessPhase && pready)
    else $error("Error raised outside an access.");

  cov_cur_ovr: cover property (@(posedge core_clk) disable iff (rst)
    $rose(curOvr));
  cov_band_ovr: cover property (@(posedge core_clk) disable iff (rst)
    $rose(bandOvr));
  cov_bad_band: cover property (@(posedge core_clk) disable iff (rst)
    bandInvalid);
  cov_err: cover property (@(posedge core_clk) disable iff (rst) pslverr);
  cov_bad_code: cover property (@(posedge core_clk) disable iff (rst)
    pumpCodeBad);
endmodule : slv_regs

// *** dv/slv_regs_tb.sv ***
// Self-checking bench for the override register bank.
`timescale 1ns/1ns
module slv_regs_tb;
  import slv_pkg::*;
  logic        core_clk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic        pumpEnable, bandInvalid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, r;
  logic [3:0]  pstrb, pumpMilliAmp;
  logic [8:0]  calCurrent, oscCurrent;
  logic [7:0]  calBand, oscBand;
  logic [2:0]  chargePumpGainCode;
  int          mismatches, cmp_count, mdl[8];
  slv_regs u_dut (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .calCurrent(calCurrent), .calBand(calBand), .oscCurrent(oscCurrent),
    .oscBand(oscBand), .chargePumpGainCode(chargePumpGainCode),
    .pumpMilliAmp(pumpMilliAmp), .pumpEnable(pumpEnable),
    .bandInvalid(bandInvalid));
  ////////////////////////////////////////////////////////////////////////
  task complete_run;
    $display("Counts: %0d mismatches, %0d comparisons", mismatches,
      cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [7:0] idx, input logic [15:0] d);
    int n;
    @(posedge core_clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {2'b00, idx, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge core_clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++)
    begin
      @(posedge core_clk);
      if (pready === 1'b1)
        break;
    end
    if (n == 16)
    begin
      mismatches++;
      complete_run();
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task wr(input logic [7:0] idx, input logic [15:0] d);
    apb(1'b1, idx, d);
    chk(er, 0);
    mdl[idx-14] = d;
  endtask : wr
  task rdc(input logic [7:0] idx);
    apb(1'b0, idx, 16'h0000);
    chk(rd, mdl[idx-14]);
    chk(er, 0);
  endtask : rdc
  // Pin outputs against the model; oscillator outputs lag by one edge.
  task osc;
    int g, ma;
    repeat (2) @(posedge core_clk);
    #1;
    g = (mdl[0] >> 4) & 7;
    ma = g == 4 ? 3 : g == 1 ? 6 : g == 5 ? 9 : g == 3 ? 12 : g == 7 ? 15 : 0;
    chk(chargePumpGainCode, g);
    chk(pumpMilliAmp, ma);
    chk(pumpEnable, ma != 0);
    chk(oscCurrent, mdl[6][14] ? mdl[2][8:0] : calCurrent);
    chk(oscBand, mdl[6][11] ? mdl[5][7:0] : calBand);
    chk(bandInvalid, mdl[6][11] && mdl[5][7:0] > 183);
  endtask : osc
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  initial
  begin
    rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0;
    pwdata = '0; pstrb = 4'hf; calCurrent = 9'h055; calBand = 8'h21;
    mdl = '{32'h1e70, 32'h064f, 32'h0080, 32'h0096, 32'h0064, 32'h27b7, 0, 0};
    void'($urandom(32'h26a85cbc));
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 14; i < 21; i++)
      rdc(i);
    osc();
    wr(15, 16'h064f);
    wr(17, 16'h012c);
    wr(18, 16'h0064);
    for (int g = 0; g < 8; g++)
    begin
      wr(14, 16'h1e00 | (g << 4));
      rdc(14);
      osc();
      apb(1'b0, 8'h15, 16'h0000);
      chk(rd, ((g == 2 || g == 6) << 2) | (g != 0 && g != 2 && g != 6));
      chk(er, 0);
    end
    for (int k = 0; k < 12; k++)
    begin
      r = $urandom;
      @(posedge core_clk);
      calCurrent <= r[8:0];
      calBand    <= r[23:16];
      wr(16, {7'h00, r[31:23]});
      wr(19, 16'h2700 | (k == 2 ? 183 : k == 3 ? 184 : r[15:8] % 184));
      wr(20, ((k & 1) << 14) | (((k >> 1) & 1) << 11));
      for (int i = 14; i < 21; i++)
        rdc(i);
      osc();
    end
    apb(1'b1, 8'h16, 16'hffff);
    chk(er, 1);
    apb(1'b1, 8'h15, 16'hffff);
    chk(er, 1);
    for (int i = 14; i < 21; i++)
      rdc(i);
    complete_run();
  end
endmodule : slv_regs_tb
